// >>> include/sdc_pkg.sv
// servo drive control-input package: register map, field positions, codes, timing
// assumes a 125 MHz core clock and a 32-bit apb register bus
package sdc_pkg;

	// core clock
	localparam int unsigned CLK_MHZ = 125;

	// servo activation latencies, figure in its own unit
	localparam int unsigned SERVO_ON_INPUT_FIRST_MS = 3200;  // 3.2 s
	localparam int unsigned SERVO_ON_INPUT_LATER_MS = 170;
	// longest times, so round down
	localparam int unsigned SERVO_ON_INPUT_FIRST_CYC = SERVO_ON_INPUT_FIRST_MS * 1000 * CLK_MHZ;
	localparam int unsigned SERVO_ON_INPUT_LATER_CYC = SERVO_ON_INPUT_LATER_MS * 1000 * CLK_MHZ;

	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_DECEL  = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_CHLIM  = 8'h10;
	localparam logic [7:0] REG_CHAN   = 8'h14;

	// control and command bits
	localparam int CTRL_LIM_INV = 0;
	localparam int CTRL_FLIP    = 1;
	localparam int CMD_DISABLE  = 0;
	localparam int CMD_ENABLE   = 1;
	localparam int CMD_ESC_B    = 2;
	localparam int CMD_ESC_C    = 3;
	localparam int CMD_WCLR     = 4;

	// deceleration fields, units of 0.1 s^-2
	localparam int DEC_STOP_LSB = 16;
	localparam logic [15:0] DEC_STOP_MAX = 16'h1F40;  // 800.0
	localparam logic [15:0] DEC_RST      = 16'h0000;
	localparam logic [7:0]  CHLIM_RST    = 8'hFF;

	// alarm and warning codes on the status display
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_F3   = 8'hF3;
	localparam logic [7:0] CODE_F5   = 8'hF5;
	localparam logic [7:0] CODE_P5   = 8'h50;

	// synchronised input vector layout
	localparam int IN_CW   = 0;
	localparam int IN_CCW  = 1;
	localparam int IN_SERVO_ON_INPUT = 2;
	localparam int IN_HALT = 3;
	localparam int IN_RUN  = 4;
	localparam int IN_PWR  = 5;
	localparam int IN_CH   = 6;
	localparam int IN_W    = 14;

	typedef enum logic [3:0] {
		SDC_SV_OFF    = 4'b0001,
		SDC_SV_WAIT   = 4'b0010,
		SDC_SV_ON     = 4'b0100,
		SDC_SV_CMDOFF = 4'b1000
	} sdc_sv_t;

	// apb request as seen by the slave
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sdc_apb_req_t;

	// whole module state
	typedef struct packed {
		logic [IN_W-1:0] s1;
		logic [IN_W-1:0] s2;
		logic [IN_W-1:0] s3;
		logic [IN_W-1:0] filt;
		logic            run_prev;
		sdc_sv_t         sv;
		logic [31:0]     cnt;
		logic            first_done;
		logic            ot;
		logic            ot_dir;
		logic            halt_decel;
		logic            warn_f5;
		logic            warn_p5;
		logic            lim_inv;
		logic            flip;
		logic [15:0]     mb;
		logic [15:0]     md;
		logic [7:0]      chan_lim;
		logic [7:0]      chan;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
		logic            svact;
		logic            drive_ok;
		logic            dbrake;
		logic            err_clr;
		logic            plus_ent;
		logic            minus_ent;
		logic [7:0]      code;
		logic            pos_go;
		logic            pos_dir;
		logic            pos_rej;
		logic            esc_go;
		logic            esc_dir;
		logic            prog_go;
		logic [15:0]     decel_rate;
		logic            pulse;
	} sdc_state_t;

endpackage : sdc_pkg

// >>> core/sdc_core.sv
// servo drive control inputs: limits, servo on, program start, halt interlock
// assumes apb master on clk_i; pins asynchronous; motion engine on clk_i
`timescale 1ns/1ps

module sdc_core #(
	parameter logic [31:0] FIRST_CYC = sdc_pkg::SERVO_ON_INPUT_FIRST_CYC,
	parameter logic [31:0] LATER_CYC = sdc_pkg::SERVO_ON_INPUT_LATER_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// discrete pins from the master controller
	input  wire logic        cw_limit_input_i,
	input  wire logic        ccw_limit_input_i,
	input  wire logic        servo_on_input_i,
	input  wire logic        halt_input_i,
	input  wire logic        prog_start_input_i,
	input  wire logic [7:0]  program_channel_select_i,
	input  wire logic        main_power_i,
	// discrete outputs to the master controller
	output logic             drive_ok_out_o,
	output logic             servo_active_out_o,
	output logic             plus_entry_flag_out_o,
	output logic             minus_entry_flag_out_o,
	output logic [7:0]       alarm_code_o,
	// motion engine status
	input  wire logic        moving_i,
	input  wire logic        motion_dir_i,
	input  wire logic        busy_i,
	input  wire logic        pos_req_i,
	input  wire logic        pos_req_dir_i,
	input  wire logic        pulse_step_i,
	// motion engine control
	output logic             pos_go_o,
	output logic             pos_dir_o,
	output logic             pos_reject_o,
	output logic             esc_go_o,
	output logic             esc_dir_o,
	output logic             ot_stop_o,
	output logic             dyn_brake_o,
	output logic             err_clear_o,
	output logic             decel_stop_o,
	output logic [15:0]      decel_rate_o,
	output logic             pulse_step_o,
	output logic             prog_go_o,
	output logic [7:0]       prog_channel_o
);

	sdc_pkg::sdc_state_t   r;
	sdc_pkg::sdc_state_t   n;
	sdc_pkg::sdc_apb_req_t bus;

	// bundle the bus request
	assign bus = '{psel: psel_i, penable: penable_i, pwrite: pwrite_i,
	               paddr: paddr_i, pwdata: pwdata_i};

	// all outputs straight from the state register
	assign prdata_o               = r.prdata;
	assign pready_o               = r.pready;
	assign pslverr_o              = r.pslverr;
	assign drive_ok_out_o         = r.drive_ok;
	assign servo_active_out_o     = r.svact;
	assign plus_entry_flag_out_o  = r.plus_ent;
	assign minus_entry_flag_out_o = r.minus_ent;
	assign alarm_code_o           = r.code;
	assign pos_go_o               = r.pos_go;
	assign pos_dir_o              = r.pos_dir;
	assign pos_reject_o           = r.pos_rej;
	assign esc_go_o               = r.esc_go;
	assign esc_dir_o              = r.esc_dir;
	assign ot_stop_o              = r.ot;
	assign dyn_brake_o            = r.dbrake;
	assign err_clear_o            = r.err_clr;
	assign decel_stop_o           = r.halt_decel;
	assign decel_rate_o           = r.decel_rate;
	assign pulse_step_o           = r.pulse;
	assign prog_go_o              = r.prog_go;
	assign prog_channel_o         = r.chan;

	// next-state logic
	always_comb begin
		logic [sdc_pkg::IN_W-1:0] agree;
		logic                     lim_cw;
		logic                     lim_ccw;
		logic                     lim_plus;
		logic                     lim_minus;
		logic                     lim_hit;
		logic                     lim_entry;
		logic                     servo_on_input;
		logic                     halt;
		logic                     pwr;
		logic                     run_edge;
		logic [7:0]               sel;
		logic                     acc;
		logic                     wr;
		logic [31:0]              cmd;
		logic                     pending;
		agree = '0;
		lim_cw = 1'b0;
		lim_ccw = 1'b0;
		lim_plus = 1'b0;
		lim_minus = 1'b0;
		lim_hit = 1'b0;
		lim_entry = 1'b0;
		servo_on_input = 1'b0;
		halt = 1'b0;
		pwr = 1'b0;
		run_edge = 1'b0;
		sel = '0;
		acc = 1'b0;
		wr = 1'b0;
		cmd = '0;
		pending = 1'b0;
		n = r;

		// three-stage sync; a change counts once stages two and three agree
		n.s1 = {program_channel_select_i, main_power_i, prog_start_input_i,
		        halt_input_i, servo_on_input_i, ccw_limit_input_i, cw_limit_input_i};
		n.s2 = r.s1;
		n.s3 = r.s2;
		agree = ~(r.s2 ^ r.s3);
		n.filt = (r.s3 & agree) | (r.filt & ~agree);
		servo_on_input = r.filt[sdc_pkg::IN_SERVO_ON_INPUT];
		halt = r.filt[sdc_pkg::IN_HALT];
		pwr  = r.filt[sdc_pkg::IN_PWR];
		sel  = r.filt[sdc_pkg::IN_CH +: 8];
		n.run_prev = r.filt[sdc_pkg::IN_RUN];
		run_edge = r.filt[sdc_pkg::IN_RUN] & ~r.run_prev;

		// limit active when the pin is off, unless polarity inverted
		lim_cw  = r.filt[sdc_pkg::IN_CW] ^ ~r.lim_inv;
		lim_ccw = r.filt[sdc_pkg::IN_CCW] ^ ~r.lim_inv;
		// flip only changes which physical side is "plus", not the pin roles
		lim_plus  = r.flip ? lim_ccw : lim_cw;
		lim_minus = r.flip ? lim_cw : lim_ccw;

		// apb: pready answers one cycle into the access phase; a write lands only at
		// the edge where the master sees pready, so it cannot land twice or early
		acc = bus.psel & bus.penable & ~r.pready;
		wr  = bus.psel & bus.penable & bus.pwrite & r.pready;
		n.pready  = acc;
		n.pslverr = 1'b0;
		n.prdata  = '0;
		// register writes
		if (wr) begin
			case (bus.paddr)
				sdc_pkg::REG_CTRL: begin
					n.lim_inv = bus.pwdata[sdc_pkg::CTRL_LIM_INV];
					n.flip    = bus.pwdata[sdc_pkg::CTRL_FLIP];
				end
				sdc_pkg::REG_CMD: begin
					cmd = bus.pwdata;
				end
				sdc_pkg::REG_DECEL: begin
					n.mb = bus.pwdata[15:0];
					// out-of-range stop deceleration is refused, old value kept
					if (bus.pwdata[31:16] <= sdc_pkg::DEC_STOP_MAX) begin
						n.md = bus.pwdata[31:16];
					end
				end
				sdc_pkg::REG_CHLIM: begin
					n.chan_lim = bus.pwdata[7:0];
				end
				default: begin
					// read-only and unmapped offsets drop the write
					cmd = '0;
				end
			endcase
		end
		// register reads and the error answer
		if (acc) begin
			case (bus.paddr)
				sdc_pkg::REG_CTRL: begin
					n.prdata = {30'h0000_0000, r.flip, r.lim_inv};
				end
				sdc_pkg::REG_CMD: begin
					n.prdata = '0;
				end
				sdc_pkg::REG_DECEL: begin
					n.prdata = {r.md, r.mb};
				end
				sdc_pkg::REG_STATUS: begin
					// state flags, filtered channel pins, display code
					n.prdata = {8'h00, r.code, r.filt[sdc_pkg::IN_CH +: 8], halt, servo_on_input,
					            r.warn_p5, r.warn_f5, r.halt_decel, r.ot_dir, r.ot, r.svact};
				end
				sdc_pkg::REG_CHLIM: begin
					n.prdata = {24'h00_0000, r.chan_lim};
				end
				sdc_pkg::REG_CHAN: begin
					n.prdata = {24'h00_0000, r.chan};
				end
				default: begin
					n.pslverr = 1'b1;
				end
			endcase
		end

		// servo sequencing
		n.err_clr = 1'b0;
		n.drive_ok = pwr;
		case (r.sv)
			sdc_pkg::SDC_SV_OFF: begin
				if (servo_on_input && pwr && r.drive_ok) begin
					n.sv  = sdc_pkg::SDC_SV_WAIT;
					n.cnt = r.first_done ? LATER_CYC : FIRST_CYC;
				end
			end
			sdc_pkg::SDC_SV_WAIT: begin
				n.cnt = r.cnt - 32'h0000_0001;
				if (!servo_on_input || !pwr) begin
					n.sv = sdc_pkg::SDC_SV_OFF;
					n.err_clr = 1'b1;
				end else if (r.cnt <= 32'h0000_0001) begin
					n.sv = sdc_pkg::SDC_SV_ON;
					n.first_done = 1'b1;
				end
			end
			sdc_pkg::SDC_SV_ON: begin
				if (!pwr) begin
					n.sv = sdc_pkg::SDC_SV_OFF;
					n.warn_p5 = 1'b1;
					n.err_clr = 1'b1;
				end else if (!servo_on_input) begin
					n.sv = sdc_pkg::SDC_SV_OFF;
					n.err_clr = 1'b1;
				end else if (cmd[sdc_pkg::CMD_DISABLE]) begin
					n.sv = sdc_pkg::SDC_SV_CMDOFF;
					// any drop from on empties the error counter
					n.err_clr = 1'b1;
				end
			end
			sdc_pkg::SDC_SV_CMDOFF: begin
				if (!servo_on_input || !pwr) begin
					n.sv = sdc_pkg::SDC_SV_OFF;
				end else if (cmd[sdc_pkg::CMD_ENABLE]) begin
					n.sv  = sdc_pkg::SDC_SV_WAIT;
					n.cnt = LATER_CYC;
				end
			end
			default: begin
				n.sv = sdc_pkg::SDC_SV_OFF;
			end
		endcase
		// status outputs follow the next state so they change with it
		n.svact  = (n.sv == sdc_pkg::SDC_SV_ON);
		// brake holds the shaft in the off and command-off states; released during the activation wait
		n.dbrake = (n.sv == sdc_pkg::SDC_SV_OFF) || (n.sv == sdc_pkg::SDC_SV_CMDOFF);

		// over-travel: only a limit in the moving direction trips
		lim_hit   = moving_i & (motion_dir_i ? lim_minus : lim_plus);
		lim_entry = r.ot_dir ? lim_minus : lim_plus;
		if (r.ot) begin
			// leaving the zone by any means, servo on or off, releases the latch
			if (!lim_entry) begin
				n.ot = 1'b0;
			end
		end else if (lim_hit) begin
			n.ot     = 1'b1;
			n.ot_dir = motion_dir_i;
		end
		n.plus_ent  = n.ot & ~n.ot_dir;
		n.minus_ent = n.ot & n.ot_dir;

		// halt: once begun, deceleration runs to standstill
		if (halt && busy_i) begin
			n.halt_decel = 1'b1;
		end else if (!moving_i) begin
			n.halt_decel = 1'b0;
		end
		// zero stop value falls back to the normal deceleration
		n.decel_rate = (r.md != sdc_pkg::DEC_RST && r.md > r.mb) ? r.md : r.mb;
		// steps are dropped, not queued, while halt stands
		n.pulse = pulse_step_i & r.svact & ~halt;

		// positioning requests from the internal command path
		n.pos_go  = 1'b0;
		n.pos_rej = 1'b0;
		n.pos_dir = pos_req_dir_i;
		if (pos_req_i) begin
			if (r.svact && !halt && !r.halt_decel && !(r.ot && pos_req_dir_i == r.ot_dir)) begin
				n.pos_go = 1'b1;
			end else begin
				n.pos_rej = 1'b1;
			end
		end

		// escape shortcut: direction is forced, never taken from software
		n.esc_go  = (cmd[sdc_pkg::CMD_ESC_B] | cmd[sdc_pkg::CMD_ESC_C]) & r.ot & r.svact & ~halt;
		n.esc_dir = ~r.ot_dir;

		// program start with its checks
		n.prog_go = 1'b0;
		pending = r.ot | r.warn_f5 | r.warn_p5;
		if (cmd[sdc_pkg::CMD_WCLR]) begin
			// clear first so a same-cycle event below wins
			n.warn_f5 = 1'b0;
			if (r.sv != sdc_pkg::SDC_SV_ON || pwr) begin
				n.warn_p5 = 1'b0;
			end
		end
		if (run_edge) begin
			n.chan = sel;
			if (busy_i || sel > r.chan_lim || !r.svact || pending) begin
				n.warn_f5 = 1'b1;
			end else if (halt) begin
				n.warn_f5 = 1'b1;
			end else begin
				n.prog_go = 1'b1;
			end
		end
		if (r.sv == sdc_pkg::SDC_SV_ON && !pwr) begin
			n.warn_p5 = 1'b1;
		end

		// display code: alarm above warnings
		if (n.ot) begin
			n.code = sdc_pkg::CODE_F3;
		end else if (n.warn_p5) begin
			n.code = sdc_pkg::CODE_P5;
		end else if (n.warn_f5) begin
			n.code = sdc_pkg::CODE_F5;
		end else begin
			n.code = sdc_pkg::CODE_NONE;
		end
	end

	// state register; reset loads constants only
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			r          <= '0;
			r.sv       <= sdc_pkg::SDC_SV_OFF;
			r.mb       <= sdc_pkg::DEC_RST;
			r.md       <= sdc_pkg::DEC_RST;
			r.chan_lim <= sdc_pkg::CHLIM_RST;
			r.dbrake   <= 1'b1;
		end else begin
			r <= n;
		end
	end

endmodule : sdc_core

// >>> testbench/sdc_checker.sv
// checker: port timing relations of the servo drive control-input block
// assumes it is bound into sdc_core and that everything runs on clk_i
`timescale 1ns/1ps

module sdc_checker (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	// watched inputs
	input wire logic       halt_input_i,
	input wire logic       pos_req_i,
	input wire logic       pos_req_dir_i,
	// watched outputs
	input wire logic       pos_go_o,
	input wire logic       pos_reject_o,
	input wire logic       decel_stop_o,
	input wire logic       ot_stop_o,
	input wire logic       servo_active_out_o,
	input wire logic       plus_entry_flag_out_o,
	input wire logic       minus_entry_flag_out_o,
	input wire logic [7:0] alarm_code_o,
	input wire logic       esc_go_o,
	input wire logic       esc_dir_o,
	input wire logic       dyn_brake_o,
	input wire logic       err_clear_o,
	input wire logic       pulse_step_o,
	input wire logic       prog_go_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	// halt held long enough to pass the pin filter
	sequence s_halt_held;
		halt_input_i [*8];
	endsequence
	sequence s_ot_entry;
		$rose(ot_stop_o);
	endsequence

	property p_ot_code;
		s_ot_entry |-> alarm_code_o == sdc_pkg::CODE_F3 && $stable(servo_active_out_o);
	endproperty
	a_ot_code: assert property (p_ot_code) else $error("over-travel code or servo wrong");
	property p_ot_flag;
		ot_stop_o |-> plus_entry_flag_out_o ^ minus_entry_flag_out_o;
	endproperty
	a_ot_flag: assert property (p_ot_flag) else $error("entry flags wrong");
	property p_pos_ans;
		pos_req_i |=> pos_go_o ^ pos_reject_o;
	endproperty
	a_pos_ans: assert property (p_pos_ans) else $error("no single answer to request");
	property p_pos_ot;
		pos_req_i && ot_stop_o && pos_req_dir_i == minus_entry_flag_out_o |=> pos_reject_o;
	endproperty
	a_pos_ot: assert property (p_pos_ot) else $error("move into limit accepted");
	property p_pos_halt;
		pos_req_i && decel_stop_o |=> pos_reject_o && !pos_go_o;
	endproperty
	a_pos_halt: assert property (p_pos_halt) else $error("move accepted while halting");
	property p_esc_dir;
		esc_go_o |-> ot_stop_o && esc_dir_o == plus_entry_flag_out_o;
	endproperty
	a_esc_dir: assert property (p_esc_dir) else $error("escape direction wrong");
	// error clear may lead or trail the status edge by one cycle
	property p_svoff;
		$fell(servo_active_out_o) |-> dyn_brake_o and ((err_clear_o || $past(err_clear_o)) or ##1 err_clear_o);
	endproperty
	a_svoff: assert property (p_svoff) else $error("servo off without brake or clear");
	property p_prog_pulse;
		prog_go_o |=> !prog_go_o;
	endproperty
	a_prog_pulse: assert property (p_prog_pulse) else $error("program start repeated");
	property p_pulse_halt;
		s_halt_held |-> !pulse_step_o;
	endproperty
	a_pulse_halt: assert property (p_pulse_halt) else $error("pulse passed during halt");
endmodule : sdc_checker

bind sdc_core sdc_checker i_sdc_checker (.*);

// >>> testbench/sdc_ctrl_model.sv
// partner model: master controller driving servo-on, start and channel pins
// assumes the bench posts requests on clk_i edges
`timescale 1ns/1ps

module sdc_ctrl_model (
	// clock
	input  wire logic       clk_i,
	// requests and drive readiness
	input  wire logic       drive_ok_i,
	input  wire logic       servo_on_input_req_i,
	input  wire logic       start_req_i,
	input  wire logic [7:0] chan_req_i,
	// pins toward the drive
	output logic            servo_on_o,
	output logic            start_o,
	output logic [7:0]      chan_o
);
	// pins known from time zero
	initial begin
		servo_on_o = 1'b0;
		start_o = 1'b0;
		chan_o = 8'h00;
	end
	// start edge held back until channel pins settled, servo-on until drive ready
	always @(posedge clk_i) begin
		servo_on_o <= servo_on_input_req_i && (servo_on_o || drive_ok_i);
		chan_o <= chan_req_i;
		start_o <= start_req_i && (start_o || chan_o == chan_req_i);
	end
endmodule : sdc_ctrl_model

// >>> testbench/tb_top.sv
// testbench: directed scenarios for the servo drive control-input block
// assumes sdc_core, the controller model and the bound checker
`timescale 1ns/1ps

module tb_top;
	logic        clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, re, esc_d;
	logic [7:0]  paddr_i, program_channel_select_i, alarm_code_o, prog_channel_o, chan_req, go_ch;
	logic [31:0] pwdata_i, prdata_o, rq;
	logic        cw_limit_input_i, ccw_limit_input_i, servo_on_input_i, halt_input_i, main_power_i;
	logic        prog_start_input_i, drive_ok_out_o, servo_active_out_o, servo_on_input_req, start_req;
	logic        plus_entry_flag_out_o, minus_entry_flag_out_o, moving_i, motion_dir_i, busy_i;
	logic        pos_req_i, pos_req_dir_i, pulse_step_i, pos_go_o, pos_dir_o, pos_reject_o;
	logic        esc_go_o, esc_dir_o, ot_stop_o, dyn_brake_o, err_clear_o, decel_stop_o;
	logic        pulse_step_o, prog_go_o;
	logic [15:0] decel_rate_o;
	int          bad_count, n_checks, go_n, n;

	// short activation counts keep the run brief
	sdc_core #(.FIRST_CYC(32'h0000_0014), .LATER_CYC(32'h0000_000A)) i_sdc_core (.*);
	sdc_ctrl_model i_sdc_ctrl_model (.clk_i(clk_i), .drive_ok_i(drive_ok_out_o), .servo_on_input_req_i(servo_on_input_req),
		.start_req_i(start_req), .chan_req_i(chan_req), .servo_on_o(servo_on_input_i),
		.start_o(prog_start_input_i), .chan_o(program_channel_select_i));

	// 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	// one-cycle pulses are caught here
	always @(posedge clk_i) begin
		if (prog_go_o === 1'b1) begin
			go_n++;
			go_ch = prog_channel_o;
		end
		if (esc_go_o === 1'b1) esc_d = esc_dir_o;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task summarize();
		if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : summarize

	task cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask : cyc

	// one apb transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rq = prdata_o;
		re = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb

	task sv_lat(input int lo);
		n = 0;
		while (servo_on_input_i !== 1'b1) @(posedge clk_i);
		while (servo_active_out_o !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		chk(n >= lo && n <= lo + 8, 1'b1);
	endtask : sv_lat

	task pos_try(input logic dir, input logic ok);
		@(posedge clk_i);
		pos_req_dir_i <= dir;
		pos_req_i <= 1'b1;
		@(posedge clk_i);
		pos_req_i <= 1'b0;
		#1;
		chk({pos_go_o, pos_reject_o}, {ok, !ok});
		chk(pos_dir_o, dir);
	endtask : pos_try

	// halt while moving; deceleration must run on after release
	task halt_rate(input logic [15:0] exp);
		moving_i <= 1'b1;
		busy_i <= 1'b1;
		halt_input_i <= 1'b1;
		cyc(8);
		chk(decel_rate_o, exp);
		pos_try(1'b0, 1'b0);
		halt_input_i <= 1'b0;
		cyc(8);
		chk(decel_stop_o, 1'b1);
		moving_i <= 1'b0;
		busy_i <= 1'b0;
		cyc(6);
		chk(decel_stop_o, 1'b0);
	endtask : halt_rate

	// start with a channel; refused starts leave a warning to clear
	task prog(input logic [7:0] ch, input logic ok);
		int g;
		g = go_n;
		chan_req <= ch;
		cyc(2);
		start_req <= 1'b1;
		cyc(10);
		start_req <= 1'b0;
		cyc(10);
		chk(go_n, g + ok);
		chk(alarm_code_o, ok ? sdc_pkg::CODE_NONE : sdc_pkg::CODE_F5);
		apb(1'b1, sdc_pkg::REG_CMD, 32'h0000_0001 << sdc_pkg::CMD_WCLR);
	endtask : prog

	initial begin
		#100000;
		bad_count++;
		summarize();
	end

	initial begin
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, halt_input_i, main_power_i} = '0;
		{moving_i, motion_dir_i, busy_i, pos_req_i, pos_req_dir_i, pulse_step_i} = '0;
		{servo_on_input_req, start_req, chan_req} = '0;
		{cw_limit_input_i, ccw_limit_input_i} = 2'b11;
		sys_rst_i = 1'b1;
		cyc(5);
		sys_rst_i <= 1'b0;
		chk(dyn_brake_o, 1'b1);
		apb(1'b0, sdc_pkg::REG_CHLIM, '0);
		chk(rq, {24'h00_0000, sdc_pkg::CHLIM_RST});
		apb(1'b0, 8'h20, '0);
		chk(re, 1'b1);
		chk(rq, 32'h0000_0000);
		// servo on, off, command off and on
		main_power_i <= 1'b1;
		servo_on_input_req <= 1'b1;
		sv_lat(20);
		servo_on_input_req <= 1'b0;
		cyc(8);
		chk({servo_active_out_o, dyn_brake_o}, 2'b01);
		servo_on_input_req <= 1'b1;
		sv_lat(10);
		apb(1'b1, sdc_pkg::REG_CMD, 32'h0000_0001 << sdc_pkg::CMD_DISABLE);
		cyc(4);
		chk(servo_active_out_o, 1'b0);
		apb(1'b1, sdc_pkg::REG_CMD, 32'h0000_0001 << sdc_pkg::CMD_ENABLE);
		sv_lat(8);
		// plus travel into the cw limit
		moving_i <= 1'b1;
		cw_limit_input_i <= 1'b0;
		cyc(8);
		chk({ot_stop_o, plus_entry_flag_out_o, minus_entry_flag_out_o, servo_active_out_o}, 4'b1101);
		chk(alarm_code_o, sdc_pkg::CODE_F3);
		pos_try(1'b0, 1'b0);
		pos_try(1'b1, 1'b1);
		for (int b = sdc_pkg::CMD_ESC_B; b <= sdc_pkg::CMD_ESC_C; b++) begin
			esc_d = 1'b0;
			apb(1'b1, sdc_pkg::REG_CMD, 32'h0000_0001 << b);
			cyc(2);
			chk(esc_d, 1'b1);
		end
		cw_limit_input_i <= 1'b1;
		cyc(8);
		chk({ot_stop_o, plus_entry_flag_out_o}, 2'b00);
		ccw_limit_input_i <= 1'b0;
		cyc(8);
		chk(ot_stop_o, 1'b0);
		// inverted polarity and flipped rotation: plus is guarded by ccw
		apb(1'b1, sdc_pkg::REG_CTRL, 32'h0000_0003);
		ccw_limit_input_i <= 1'b1;
		cw_limit_input_i <= 1'b0;
		cyc(8);
		chk({ot_stop_o, plus_entry_flag_out_o}, 2'b11);
		ccw_limit_input_i <= 1'b0;
		moving_i <= 1'b0;
		cyc(8);
		apb(1'b1, sdc_pkg::REG_CTRL, 32'h0000_0000);
		{cw_limit_input_i, ccw_limit_input_i} <= 2'b11;
		cyc(8);
		// halt: larger deceleration wins, out-of-range stop value ignored
		apb(1'b1, sdc_pkg::REG_DECEL, 32'h0032_001E);
		halt_rate(16'h0032);
		apb(1'b1, sdc_pkg::REG_DECEL, 32'h1F41_0064);
		apb(1'b0, sdc_pkg::REG_DECEL, '0);
		chk(rq, 32'h0032_0064);
		halt_rate(16'h0064);
		halt_input_i <= 1'b1;
		cyc(8);
		repeat (4) begin
			@(posedge clk_i);
			pulse_step_i <= ~pulse_step_i;
			#1;
			chk(pulse_step_o, 1'b0);
		end
		halt_input_i <= 1'b0;
		pulse_step_i <= 1'b0;
		cyc(8);
		@(posedge clk_i);
		pulse_step_i <= 1'b1;
		@(posedge clk_i);
		pulse_step_i <= 1'b0;
		#1;
		chk(pulse_step_o, 1'b1);
		cyc(6);
		// program start cases
		prog(8'h05, 1'b1);
		chk(go_ch, 8'h05);
		apb(1'b1, sdc_pkg::REG_CHLIM, 32'h0000_0004);
		prog(8'h05, 1'b0);
		apb(1'b1, sdc_pkg::REG_CHLIM, 32'h0000_00FF);
		busy_i <= 1'b1;
		prog(8'h03, 1'b0);
		busy_i <= 1'b0;
		halt_input_i <= 1'b1;
		prog(8'h03, 1'b0);
		halt_input_i <= 1'b0;
		cyc(8);
		// main power lost with servo on
		main_power_i <= 1'b0;
		cyc(10);
		chk(alarm_code_o, sdc_pkg::CODE_P5);
		chk(drive_ok_out_o, 1'b0);
		summarize();
	end
endmodule : tb_top
